//--- design/buffer_channel.sv
// One buffer channel: configuration, status, activation and host control
`include "channel_defs.svh"
module buffer_channel
	import channel_pkg::*;
#(
	parameter int CH_INDEX = 0
)
(
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// Network master side register port
	input  wire logic             net_wr,
	input  wire logic             net_rd,
	input  wire logic [15:0]      net_addr,
	input  wire logic [7:0]       net_wdata,
	output logic      [7:0]       net_rdata_r,
	// Host side register port
	input  wire logic             host_wr,
	input  wire logic             host_rd,
	input  wire logic [15:0]      host_addr,
	input  wire logic [7:0]       host_wdata,
	output logic      [7:0]       host_rdata_r,
	// Buffer access events from the memory arbiter
	input  wire logic             buf_wr_first,
	input  wire logic             buf_wr_done,
	input  wire logic             buf_rd_first,
	input  wire logic             buf_rd_done,
	input  wire logic             host_start_access,
	// Channel configuration and state
	output logic      [15:0]      cfg_start_r,
	output logic      [15:0]      cfg_len_r,
	output channel_pkg::mode_type cfg_mode_r,
	output channel_pkg::dir_type  cfg_dir_r,
	output logic                  supervise_r,
	output logic                  mem_lock_r,
	output logic                  act_changed_r,
	output logic                  repeat_pending_r,
	output logic                  latch_host_r,
	output logic                  latch_net_r
);
	import channel_pkg::*;

	localparam logic [15:0] BASE =
		16'(`CH_BASE + CH_INDEX * `CH_STRIDE);

	logic [7:0] ctl_hi_r;
	logic [7:0] act_r;
	logic       ack_r;
	logic       deact_r;
	logic       net_hit;
	logic       host_hit;
	logic [2:0] net_off;
	logic [2:0] host_off;
	logic       cfg_wr;
	logic       net_act_wr;
	logic       host_act_rd;
	logic       active;
	logic       host_xchg;
	logic       net_xchg;
	logic [7:0] status;
	logic [7:0] act_nxt;

	buf_event_if ev ();

	assign net_hit  = (net_addr[15:3] == BASE[15:3]);
	assign host_hit = (host_addr[15:3] == BASE[15:3]);
	assign net_off  = net_addr[2:0];
	assign host_off = host_addr[2:0];
	// Writes to geometry are ignored once the channel is enabled
	assign cfg_wr = net_wr && net_hit && !act_r[`ACT_ENABLE];
	assign net_act_wr  = net_wr && net_hit && net_off == `OFF_ACTIVATE;
	assign host_act_rd = host_rd && host_hit && host_off == `OFF_ACTIVATE;
	assign active = act_r[`ACT_ENABLE] && !deact_r;

	// Who exchanges a buffer depends on the transfer direction
	assign host_xchg = (cfg_dir_r == DIR_NET_WRITE) ? buf_rd_done
		: buf_wr_done;
	assign net_xchg  = (cfg_dir_r == DIR_NET_WRITE) ? buf_wr_done
		: buf_rd_done;

	assign ev.wr_first = buf_wr_first;
	assign ev.wr_done  = buf_wr_done;
	assign ev.rd_first = buf_rd_first;
	assign ev.rd_done  = buf_rd_done;
	assign ev.active   = supervise_r;
	assign ev.mode     = cfg_mode_r;

	channel_status_track track
	(
		.clock (clock),
		.rst   (rst),
		.ev    (ev.trk)
	);

	// Reserved writable bits are dropped, so they always read zero
	always_comb
	begin
		act_nxt = `BYTE_ZERO;
		act_nxt[`ACT_LATCH_HOST] = net_wdata[`ACT_LATCH_HOST];
		act_nxt[`ACT_LATCH_NET]  = net_wdata[`ACT_LATCH_NET];
		act_nxt[`ACT_REPEAT]     = net_wdata[`ACT_REPEAT];
		act_nxt[`ACT_ENABLE]     = net_wdata[`ACT_ENABLE];
	end

	always_comb
	begin
		status = `BYTE_ZERO;
		status[`ST_WR_OPEN] = ev.wr_open;
		status[`ST_RD_OPEN] = ev.rd_open;
		if (cfg_mode_r == MODE_TRIPLE)
			status[`ST_LAST_HI:`ST_LAST_LO] = ev.last_buf;
		if (cfg_mode_r == MODE_MAILBOX)
			status[`ST_MBX_FULL] = ev.mbx_full;
		status[`ST_IRQ_RD] = ev.irq_rd;
		status[`ST_IRQ_WR] = ev.irq_wr;
	end

	// Geometry and control, written by the network master only
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cfg_start_r <= `WORD_ZERO;
			cfg_len_r   <= `WORD_ZERO;
			ctl_hi_r    <= `BYTE_ZERO;
			cfg_mode_r  <= MODE_TRIPLE;
			cfg_dir_r   <= DIR_NET_READ;
		end
		else if (cfg_wr)
		begin
			case (net_off)
				`OFF_START_LO: cfg_start_r[7:0]  <= net_wdata;
				`OFF_START_HI: cfg_start_r[15:8] <= net_wdata;
				`OFF_LEN_LO:   cfg_len_r[7:0]    <= net_wdata;
				`OFF_LEN_HI:   cfg_len_r[15:8]   <= net_wdata;
				`OFF_CONTROL:
				begin
					ctl_hi_r   <= {net_wdata[7:4], 4'h0};
					cfg_mode_r <= mode_type'(
						net_wdata[`CTL_MODE_HI:`CTL_MODE_LO]);
					cfg_dir_r  <= dir_type'(
						net_wdata[`CTL_DIR_HI:`CTL_DIR_LO]);
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			act_r <= `BYTE_ZERO;
		else if (net_act_wr)
			act_r <= act_nxt;
	end

	// A fresh change beats a host read in the same cycle
	always_ff @(posedge clock)
	begin
		if (rst)
			act_changed_r <= 1'b0;
		else if (net_act_wr && act_nxt != act_r)
			act_changed_r <= 1'b1;
		else if (host_act_rd)
			act_changed_r <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ack_r   <= 1'b0;
			deact_r <= 1'b0;
		end
		else if (host_wr && host_hit && host_off == `OFF_HOST_CTL)
		begin
			ack_r   <= host_wdata[`HCTL_ACK];
			deact_r <= host_wdata[`HCTL_DEACT];
		end
	end

	// Reserved modes leave the area unsupervised
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			supervise_r      <= 1'b0;
			mem_lock_r       <= 1'b0;
			repeat_pending_r <= 1'b0;
		end
		else
		begin
			supervise_r <= active && cfg_len_r >= `MIN_LEN
				&& (cfg_mode_r == MODE_TRIPLE
				|| cfg_mode_r == MODE_MAILBOX);
			mem_lock_r <= deact_r;
			repeat_pending_r <= act_r[`ACT_REPEAT] != ack_r;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			latch_host_r <= 1'b0;
			latch_net_r  <= 1'b0;
		end
		else
		begin
			latch_host_r <= act_r[`ACT_LATCH_HOST] && supervise_r
				&& (host_xchg || host_start_access);
			latch_net_r  <= act_r[`ACT_LATCH_NET] && supervise_r
				&& net_xchg;
		end
	end

	// Reads answer one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			net_rdata_r  <= `BYTE_ZERO;
			host_rdata_r <= `BYTE_ZERO;
		end
		else
		begin
			if (net_rd && net_hit)
			begin
				case (net_off)
					`OFF_START_LO: net_rdata_r <= cfg_start_r[7:0];
					`OFF_START_HI: net_rdata_r <= cfg_start_r[15:8];
					`OFF_LEN_LO:   net_rdata_r <= cfg_len_r[7:0];
					`OFF_LEN_HI:   net_rdata_r <= cfg_len_r[15:8];
					`OFF_CONTROL:  net_rdata_r <= ctl_hi_r
						| {4'h0, cfg_dir_r, cfg_mode_r};
					`OFF_STATUS:   net_rdata_r <= status;
					`OFF_ACTIVATE: net_rdata_r <= act_r;
					default:       net_rdata_r <= {6'h00, ack_r, deact_r};
				endcase
			end
			else
				net_rdata_r <= `BYTE_ZERO;
			if (host_rd && host_hit)
			begin
				case (host_off)
					`OFF_START_LO: host_rdata_r <= cfg_start_r[7:0];
					`OFF_START_HI: host_rdata_r <= cfg_start_r[15:8];
					`OFF_LEN_LO:   host_rdata_r <= cfg_len_r[7:0];
					`OFF_LEN_HI:   host_rdata_r <= cfg_len_r[15:8];
					`OFF_CONTROL:  host_rdata_r <= ctl_hi_r
						| {4'h0, cfg_dir_r, cfg_mode_r};
					`OFF_STATUS:   host_rdata_r <= status;
					`OFF_ACTIVATE: host_rdata_r <= act_r;
					default: host_rdata_r <= {6'h00, ack_r, deact_r};
				endcase
			end
			else
				host_rdata_r <= `BYTE_ZERO;
		end
	end

	chk_cfg_locked: assert property (@(posedge clock) disable iff (rst)
		net_wr && net_hit && net_off <= `OFF_CONTROL && act_r[`ACT_ENABLE]
		|=> {cfg_start_r, cfg_len_r} == $past({cfg_start_r, cfg_len_r}))
		else $error("length changed while channel enabled");
	chk_act_read_clr: assert property (@(posedge clock) disable iff (rst)
		host_act_rd && !net_act_wr |=> !act_changed_r)
		else $error("activation changed flag survived host read");
	chk_deact_lock: assert property (@(posedge clock) disable iff (rst)
		host_wr && host_hit && host_off == `OFF_HOST_CTL
		&& host_wdata[`HCTL_DEACT] |=> ##1 mem_lock_r && !supervise_r)
		else $error("deactivation request did not lock channel");
	chk_repeat_match: assert property (@(posedge clock) disable iff (rst)
		host_wr && host_hit && host_off == `OFF_HOST_CTL && !net_act_wr
		&& host_wdata[`HCTL_ACK] == act_r[`ACT_REPEAT]
		|=> ##1 !repeat_pending_r)
		else $error("repeat still pending after matching acknowledge");
	chk_latch_net: assert property (@(posedge clock) disable iff (rst)
		act_r[`ACT_LATCH_NET] && supervise_r && net_xchg |=> latch_net_r)
		else $error("no latch event on master exchange");
	chk_latch_host: assert property (@(posedge clock) disable iff (rst)
		!act_r[`ACT_LATCH_HOST] |=> !latch_host_r)
		else $error("host latch event while disabled");
	chk_disable_free: assert property (@(posedge clock) disable iff (rst)
		!act_r[`ACT_ENABLE] |=> !supervise_r)
		else $error("supervision while channel disabled");
	chk_mode_reserved: assert property (@(posedge clock) disable iff (rst)
		host_rd && host_hit && host_off == `OFF_STATUS
		&& cfg_mode_r != MODE_MAILBOX |=> !host_rdata_r[`ST_MBX_FULL])
		else $error("mailbox bit set outside mailbox mode");
endmodule : buffer_channel

//--- design/channel_defs.svh
// Address map, field positions and reset values of one buffer channel
`ifndef CHANNEL_DEFS_SVH
`define CHANNEL_DEFS_SVH

`define CH_BASE        16'h0800
`define CH_STRIDE      16'h0008
`define CH_COUNT       8

`define OFF_START_LO   3'h0
`define OFF_START_HI   3'h1
`define OFF_LEN_LO     3'h2
`define OFF_LEN_HI     3'h3
`define OFF_CONTROL    3'h4
`define OFF_STATUS     3'h5
`define OFF_ACTIVATE   3'h6
`define OFF_HOST_CTL   3'h7

`define ACT_LATCH_HOST 7
`define ACT_LATCH_NET  6
`define ACT_REPEAT     1
`define ACT_ENABLE     0

`define HCTL_ACK       1
`define HCTL_DEACT     0

`define ST_WR_OPEN     7
`define ST_RD_OPEN     6
`define ST_LAST_HI     5
`define ST_LAST_LO     4
`define ST_MBX_FULL    3
`define ST_IRQ_RD      1
`define ST_IRQ_WR      0

`define CTL_MODE_HI    1
`define CTL_MODE_LO    0
`define CTL_DIR_HI     3
`define CTL_DIR_LO     2

`define LAST_FIRST     2'h0
`define LAST_SECOND    2'h1
`define LAST_THIRD     2'h2
`define LAST_NONE      2'h3

`define MIN_LEN        16'h0002
`define BYTE_ZERO      8'h00
`define WORD_ZERO      16'h0000

`endif

//--- design/channel_pkg.sv
// Types shared by the buffer channel modules
package channel_pkg;
	typedef enum logic [1:0]
	{
		MODE_TRIPLE  = 2'h0,
		MODE_RSVD_A  = 2'h1,
		MODE_MAILBOX = 2'h2,
		MODE_RSVD_B  = 2'h3
	} mode_type;

	typedef enum logic [1:0]
	{
		DIR_NET_READ  = 2'h0,
		DIR_NET_WRITE = 2'h1,
		DIR_RSVD_A    = 2'h2,
		DIR_RSVD_B    = 2'h3
	} dir_type;
endpackage : channel_pkg

//--- design/buf_event_if.sv
// Buffer access events and the status that the tracker keeps
interface buf_event_if;
	import channel_pkg::*;
	logic       wr_first;
	logic       wr_done;
	logic       rd_first;
	logic       rd_done;
	logic       active;
	mode_type   mode;
	logic       wr_open;
	logic       rd_open;
	logic [1:0] last_buf;
	logic       mbx_full;
	logic       irq_rd;
	logic       irq_wr;

	modport src
	(
		output wr_first, wr_done, rd_first, rd_done, active, mode,
		input  wr_open, rd_open, last_buf, mbx_full, irq_rd, irq_wr
	);
	modport trk
	(
		input  wr_first, wr_done, rd_first, rd_done, active, mode,
		output wr_open, rd_open, last_buf, mbx_full, irq_rd, irq_wr
	);
endinterface : buf_event_if

//--- design/channel_status_track.sv
// Buffer open, last written buffer, mailbox fill and completion flags
`include "channel_defs.svh"
module channel_status_track
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Events and status
	buf_event_if.trk ev
);
	import channel_pkg::*;

	logic mbx;
	assign mbx = (ev.mode == MODE_MAILBOX);

	// Open flags track a buffer from its first byte to its completion
	always_ff @(posedge clock)
	begin
		if (rst || !ev.active)
		begin
			ev.wr_open <= 1'b0;
			ev.rd_open <= 1'b0;
		end
		else
		begin
			if (ev.wr_done)
				ev.wr_open <= 1'b0;
			else if (ev.wr_first)
				ev.wr_open <= 1'b1;
			if (ev.rd_done)
				ev.rd_open <= 1'b0;
			else if (ev.rd_first)
				ev.rd_open <= 1'b1;
		end
	end

	// Writer rotates through three buffers; simple ring order
	always_ff @(posedge clock)
	begin
		if (rst || !ev.active || mbx)
			ev.last_buf <= `LAST_NONE;
		else if (ev.wr_done)
		begin
			case (ev.last_buf)
				`LAST_FIRST:  ev.last_buf <= `LAST_SECOND;
				`LAST_SECOND: ev.last_buf <= `LAST_THIRD;
				default:      ev.last_buf <= `LAST_FIRST;
			endcase
		end
	end

	// Full wins if a write completes as a read completes
	always_ff @(posedge clock)
	begin
		if (rst || !ev.active || !mbx)
			ev.mbx_full <= 1'b0;
		else if (ev.wr_done)
			ev.mbx_full <= 1'b1;
		else if (ev.rd_done)
			ev.mbx_full <= 1'b0;
	end

	// Set beats clear so no completion is lost
	always_ff @(posedge clock)
	begin
		if (rst || !ev.active)
		begin
			ev.irq_rd <= 1'b0;
			ev.irq_wr <= 1'b0;
		end
		else
		begin
			if (ev.rd_done)
				ev.irq_rd <= 1'b1;
			else if (ev.wr_first)
				ev.irq_rd <= 1'b0;
			if (ev.wr_done)
				ev.irq_wr <= 1'b1;
			else if (ev.rd_first)
				ev.irq_wr <= 1'b0;
		end
	end

	chk_irq_wr_set: assert property (@(posedge clock) disable iff (rst)
		ev.active && ev.wr_done |=> ev.irq_wr)
		else $error("write flag not set after completed write");
	chk_irq_rd_clear: assert property (@(posedge clock) disable iff (rst)
		ev.active && ev.wr_first && !ev.rd_done |=> !ev.irq_rd)
		else $error("read flag not cleared by first write byte");
	chk_mbx_fill: assert property (@(posedge clock) disable iff (rst)
		ev.active && mbx && ev.wr_done |=> ev.mbx_full)
		else $error("mailbox not full after completed write");
	chk_last_none: assert property (@(posedge clock) disable iff (rst)
		!ev.active |=> ev.last_buf == `LAST_NONE)
		else $error("last buffer not reset while inactive");
	chk_wr_open: assert property (@(posedge clock) disable iff (rst)
		ev.active && ev.wr_first && !ev.wr_done |=> ev.wr_open)
		else $error("write buffer not marked open");
endmodule : channel_status_track

//--- testbench/buffer_event_model.sv
// Memory arbiter stand-in raising one buffer access event at a time
module buffer_event_model
(
	// Clock
	input  wire logic clock,
	// Buffer events
	output logic      wr_first,
	output logic      wr_done,
	output logic      rd_first,
	output logic      rd_done,
	output logic      start_access
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [4:0] ev_r = 5'h00;

	assign {start_access, rd_done, rd_first, wr_done, wr_first} = ev_r;

	// Gap lets the arbiter answer promptly or late
	task automatic pulse(input int k, input int gap);
		repeat (gap) @(posedge clock);
		@(posedge clock);
		ev_r <= 5'h01 << k;
		@(posedge clock);
		ev_r <= 5'h00;
		#1;
	endtask : pulse
endmodule : buffer_event_model

//--- testbench/buffer_channel_bench.sv
// Self-checking bench for one buffer channel
module buffer_channel_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import channel_pkg::*;

	localparam logic [15:0] BASE = 16'h0818;

	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        net_wr = 1'b0;
	logic        net_rd = 1'b0;
	logic [15:0] net_addr = 16'h0000;
	logic [7:0]  net_wdata = 8'h00;
	logic [7:0]  net_rdata;
	logic        host_wr = 1'b0;
	logic        host_rd = 1'b0;
	logic [15:0] host_addr = 16'h0000;
	logic [7:0]  host_wdata = 8'h00;
	logic [7:0]  host_rdata;
	logic        wf, wd, rf, rd, sa;
	logic [15:0] cfg_start, cfg_len;
	mode_type    cfg_mode;
	dir_type     cfg_dir;
	logic        supervise, mem_lock, act_changed, rep_pend;
	logic        latch_host, latch_net;
	logic [7:0]  rd_val;
	logic [15:0] rnd;
	integer      seed;
	int          mismatches = 0;
	int          n_checks = 0;

	always #2.5 clock = ~clock;

	buffer_event_model u_far
	(
		.clock        (clock),
		.wr_first     (wf),
		.wr_done      (wd),
		.rd_first     (rf),
		.rd_done      (rd),
		.start_access (sa)
	);

	buffer_channel #(.CH_INDEX(3)) u_dut
	(
		.clock             (clock),
		.rst               (rst),
		.net_wr            (net_wr),
		.net_rd            (net_rd),
		.net_addr          (net_addr),
		.net_wdata         (net_wdata),
		.net_rdata_r       (net_rdata),
		.host_wr           (host_wr),
		.host_rd           (host_rd),
		.host_addr         (host_addr),
		.host_wdata        (host_wdata),
		.host_rdata_r      (host_rdata),
		.buf_wr_first      (wf),
		.buf_wr_done       (wd),
		.buf_rd_first      (rf),
		.buf_rd_done       (rd),
		.host_start_access (sa),
		.cfg_start_r       (cfg_start),
		.cfg_len_r         (cfg_len),
		.cfg_mode_r        (cfg_mode),
		.cfg_dir_r         (cfg_dir),
		.supervise_r       (supervise),
		.mem_lock_r        (mem_lock),
		.act_changed_r     (act_changed),
		.repeat_pending_r  (rep_pend),
		.latch_host_r      (latch_host),
		.latch_net_r       (latch_net)
	);

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : chk

	task automatic conclude;
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// One byte access; strobe held until the edge that takes it
	task automatic acc(input logic host, input logic wr,
		input logic [15:0] addr, input logic [7:0] d);
		@(posedge clock);
		if (host)
		begin
			host_wr    <= wr;
			host_rd    <= ~wr;
			host_addr  <= addr;
			host_wdata <= d;
		end
		else
		begin
			net_wr    <= wr;
			net_rd    <= ~wr;
			net_addr  <= addr;
			net_wdata <= d;
		end
		@(posedge clock);
		host_wr <= 1'b0;
		host_rd <= 1'b0;
		net_wr  <= 1'b0;
		net_rd  <= 1'b0;
		#1;
		rd_val = host ? host_rdata : net_rdata;
	endtask : acc

	task automatic wr(input logic host, input logic [2:0] off,
		input logic [7:0] d);
		acc(host, 1'b1, BASE + 16'(off), d);
	endtask : wr

	task automatic rdchk(input logic host, input logic [2:0] off,
		input logic [7:0] exp);
		acc(host, 1'b0, BASE + 16'(off), 8'h00);
		chk(rd_val, exp);
	endtask : rdchk

	// Derived outputs land one edge after the write is taken
	task automatic settle;
		repeat (2) @(posedge clock);
		#1;
	endtask : settle

	task automatic ev(input int k);
		u_far.pulse(k, $unsigned($random(seed)) % 4);
	endtask : ev

	function automatic logic [7:0] st(input logic wo, input logic ro,
		input logic [1:0] last, input logic full, input logic irr,
		input logic irw);
		return {wo, ro, last, full, 1'b0, irr, irw};
	endfunction : st

	initial
	begin
		#100000;
		mismatches++;
		conclude();
	end

	initial
	begin
		seed = 32'hfdb2cc5f;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		rdchk(1, 3'h5, st(0, 0, 2'h3, 0, 0, 0));
		rdchk(0, 3'h6, 8'h00);
		rdchk(1, 3'h7, 8'h00);
		// Configure while disabled: triple buffer, master writes
		rnd = 16'($random(seed));
		wr(0, 3'h0, rnd[7:0]);
		wr(0, 3'h1, rnd[15:8]);
		wr(0, 3'h2, 8'h10);
		wr(0, 3'h3, 8'h00);
		wr(0, 3'h4, 8'h04);
		settle();
		chk(cfg_start, rnd);
		chk(cfg_len, 16'h0010);
		chk(cfg_dir, DIR_NET_WRITE);
		// Reserved activation bits offered as ones
		wr(0, 3'h6, 8'hfd);
		settle();
		chk(supervise, 1'b1);
		chk(act_changed, 1'b1);
		rdchk(1, 3'h6, 8'hc1);
		chk(act_changed, 1'b0);
		wr(0, 3'h0, ~rnd[7:0]);
		wr(0, 3'h2, 8'hff);
		settle();
		chk(cfg_start, rnd);
		chk(cfg_len, 16'h0010);
		for (int i = 0; i < 4; i++)
		begin
			ev(1);
			chk(latch_net, 1'b1);
			rdchk(1, 3'h5, st(0, 0, (i == 3) ? 2'h0 : 2'(i), 0, 0, 1));
		end
		ev(4);
		chk(latch_host, 1'b1);
		ev(2);
		rdchk(1, 3'h5, st(0, 1, 2'h0, 0, 0, 0));
		ev(3);
		chk(latch_host, 1'b1);
		rdchk(1, 3'h5, st(0, 0, 2'h0, 0, 1, 0));
		ev(0);
		rdchk(1, 3'h5, st(1, 0, 2'h0, 0, 0, 0));
		ev(1);
		rdchk(0, 3'h5, st(0, 0, 2'h1, 0, 0, 1));
		// Reserved mode code keeps the channel unsupervised
		wr(0, 3'h6, 8'h00);
		wr(0, 3'h4, 8'h05);
		wr(0, 3'h6, 8'h01);
		settle();
		chk(supervise, 1'b0);
		wr(0, 3'h6, 8'h00);
		wr(0, 3'h4, 8'h06);
		wr(0, 3'h6, 8'h01);
		settle();
		chk(cfg_mode, MODE_MAILBOX);
		rdchk(1, 3'h5, 8'h00);
		ev(1);
		chk(latch_net, 1'b0);
		rdchk(1, 3'h5, st(0, 0, 2'h0, 1, 0, 1));
		ev(2);
		rdchk(1, 3'h5, st(0, 1, 2'h0, 1, 0, 0));
		ev(3);
		rdchk(1, 3'h5, st(0, 0, 2'h0, 0, 1, 0));
		// Master toggles repeat, host copies it back
		wr(0, 3'h6, 8'h03);
		settle();
		chk(rep_pend, 1'b1);
		rdchk(1, 3'h6, 8'h03);
		chk(act_changed, 1'b0);
		wr(1, 3'h7, 8'h02);
		settle();
		chk(rep_pend, 1'b0);
		wr(1, 3'h7, 8'h03);
		settle();
		chk(mem_lock, 1'b1);
		chk(supervise, 1'b0);
		rdchk(1, 3'h7, 8'h03);
		wr(1, 3'h7, 8'h02);
		settle();
		chk(mem_lock, 1'b0);
		chk(supervise, 1'b1);
		// Read-only places ignore writes
		wr(1, 3'h6, 8'h00);
		rdchk(0, 3'h6, 8'h03);
		wr(0, 3'h5, 8'hff);
		rdchk(1, 3'h5, 8'h00);
		// Master reads, host writes: host exchange is a written buffer
		wr(0, 3'h6, 8'h80);
		wr(0, 3'h4, 8'h70);
		rdchk(1, 3'h4, 8'h70);
		wr(0, 3'h6, 8'h81);
		settle();
		ev(1);
		chk(latch_host, 1'b1);
		chk(latch_net, 1'b0);
		@(posedge clock);
		#1;
		chk(latch_host, 1'b0);
		// Reset in mid-run returns every register to its default
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rdchk(1, 3'h5, 8'h30);
		rdchk(0, 3'h6, 8'h00);
		rdchk(1, 3'h7, 8'h00);
		chk(supervise, 1'b0);
		chk(cfg_len, 16'h0000);
		chk(mem_lock, 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			rnd = 16'($random(seed));
			if (rnd[15:3] == BASE[15:3])
				rnd[5] = ~rnd[5];
			acc(i[0], 1'b0, rnd, 8'h00);
			chk(rd_val, 8'h00);
		end
		conclude();
	end
endmodule : buffer_channel_bench
